//--- rtl/ccdiv_pkg.sv
// Shared constants for the cascaded channel clock divider.
package ccdiv_pkg;
   // Register indices; the byte address on the bus is four times the index.
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned IDX_W = 10;
   localparam logic [9:0] IDX_STAGE1_CNT = 10'h19e;
   localparam logic [9:0] IDX_PHASE = 10'h19f;
   localparam logic [9:0] IDX_STAGE2_CNT = 10'h1a0;
   localparam logic [9:0] IDX_BYP_CTL = 10'h1a1;
   localparam logic [9:0] IDX_DUTY = 10'h1a2;

   // Values after reset.
   localparam logic [7:0] RST_STAGE1_CNT = 8'h00;
   localparam logic [7:0] RST_PHASE = 8'h00;
   localparam logic [7:0] RST_STAGE2_CNT = 8'h00;
   localparam logic [5:0] RST_BYP_CTL = 6'h00;
   localparam logic RST_DCC_OFF = 1'h0;

   // Field positions.
   localparam int unsigned POS_LOW = 4;
   localparam int unsigned POS_HIGH = 0;
   localparam int unsigned POS_PHASE2 = 4;
   localparam int unsigned POS_PHASE1 = 0;
   localparam int unsigned BIT_BYP2 = 5;
   localparam int unsigned BIT_BYP1 = 4;
   localparam int unsigned BIT_IGNORE = 3;
   localparam int unsigned BIT_FORCE = 2;
   localparam int unsigned BIT_START2 = 1;
   localparam int unsigned BIT_START1 = 0;
   localparam int unsigned BIT_DCC_OFF = 0;
   localparam int unsigned CTL_W = 6;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Pin synchroniser depth.
   localparam int unsigned SYNC_DEPTH = 3;
endpackage

//--- rtl/ccdiv_stage.sv
// One sub-divider stage counting rising edges of its input clock.
`timescale 1ns/100ps
module ccdiv_stage
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Input clock as a level and its rising-edge tick
   input wire logic levelIn,
   input wire logic tickIn,
   // Settings
   input wire logic hold,
   input wire logic bypass,
   input wire logic [3:0] lowCnt,
   input wire logic [3:0] highCnt,
   input wire logic [3:0] phase,
   input wire logic startHigh,
   // Stage output
   output logic levelOut
);
   typedef struct packed {
      logic [3:0] cnt;
      logic [3:0] phaseCnt;
      logic waiting;
      logic level;
   } ccdiv_stage_st_t;

   ccdiv_stage_st_t s_ff;
   ccdiv_stage_st_t nxt_s;
   logic [3:0] limit;

   assign levelOut = s_ff.level;

   always_comb
   begin
      nxt_s = s_ff;
      limit = s_ff.level ? highCnt : lowCnt;
      if (bypass)
      begin
         // Counting logic is parked; the input passes straight through.
         nxt_s.cnt = 4'h0;
         nxt_s.phaseCnt = 4'h0;
         nxt_s.waiting = 1'b0;
         nxt_s.level = levelIn;
      end
      else if (hold)
      begin
         nxt_s.cnt = 4'h0;
         nxt_s.phaseCnt = phase;
         nxt_s.waiting = 1'b1;
         nxt_s.level = startHigh;
      end
      else if (tickIn)
      begin
         if (s_ff.waiting && (s_ff.phaseCnt != 4'h0))
         begin
            nxt_s.phaseCnt = s_ff.phaseCnt - 4'h1;
         end
         else
         begin
            nxt_s.waiting = 1'b0;
            if (s_ff.cnt == limit)
            begin
               nxt_s.cnt = 4'h0;
               nxt_s.level = ~s_ff.level;
            end
            else
            begin
               nxt_s.cnt = s_ff.cnt + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   bypassPass_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      bypass |=> levelOut == $past(levelIn))
      else $error("bypassed stage does not follow its input");

   holdStart_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (hold && !bypass) |=> (levelOut == $past(startHigh)) && s_ff.waiting)
      else $error("held stage not at its start level");

   highEnd_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (!bypass && !hold && tickIn && !s_ff.waiting && s_ff.level && s_ff.cnt == highCnt)
      |=> !levelOut)
      else $error("high phase did not end after high count plus one");

   lowKeep_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (!bypass && !hold && tickIn && !s_ff.waiting && !s_ff.level && s_ff.cnt < lowCnt)
      |=> !levelOut && s_ff.cnt == $past(s_ff.cnt) + 4'h1)
      else $error("low phase ended early");

   phaseWait_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (!bypass && !hold && tickIn && s_ff.waiting && s_ff.phaseCnt != 4'h0)
      |=> $stable(levelOut) && s_ff.phaseCnt == $past(s_ff.phaseCnt) - 4'h1)
      else $error("phase offset not counted down");

   levelSteady_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (!bypass && !hold && !tickIn) ##1 (!bypass && !hold && !tickIn) |=> $stable(levelOut))
      else $error("stage output moved without an input edge");
endmodule // ccdiv_stage

//--- rtl/ccdiv_top.sv
// Channel clock divider of two cascaded stages with an AXI4-Lite register slave.
// What this block does
// - Second stage low time is field plus one
// - Second stage high time is field plus one
// - First stage low and high likewise plus one
// - Upper phase nibble delays the second stage
// - Lower phase nibble delays the first stage
// - Second stage bypass passes its input through
// - First stage bypass passes its input through
// - Ignore bit makes divider disregard alignment requests
// - Force bit sets static output high or low while an ignored alignment request is present
// - Second stage start level after alignment chosen
// - First stage start level chosen by bit
// - Duty correction disable bit turns correction off
`timescale 1ns/100ps
module ccdiv_top
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Distribution clock and chip-level alignment request pins
   input wire logic clkTreeIn,
   input wire logic alignReq,
   // Channel output and duty correction enable to the output drivers
   output logic chanClkOut,
   output logic dutyCorrEn,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ccdiv_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ccdiv_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   typedef struct packed {
      logic [ccdiv_pkg::SYNC_DEPTH-1:0] treeSync;
      logic treeLvl;
      logic treePrev;
      logic [ccdiv_pkg::SYNC_DEPTH-1:0] alignSync;
      logic alignLvl;
      logic stage1Prev;
      logic [7:0] stage1Cnt;
      logic [7:0] phase;
      logic [7:0] stage2Cnt;
      logic [ccdiv_pkg::CTL_W-1:0] bypCtl;
      logic duty_correction_disable;
      logic awRdy;
      logic awHave;
      logic [ccdiv_pkg::IDX_W-1:0] awIdx;
      logic wRdy;
      logic wHave;
      logic [7:0] wData;
      logic wLane0;
      logic bValid;
      logic [1:0] bResp;
      logic arRdy;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic chanClk;
      logic dutyCorr;
   } ccdiv_top_st_t;

   localparam ccdiv_top_st_t ST_RST = '{
      stage1Cnt: ccdiv_pkg::RST_STAGE1_CNT,
      phase: ccdiv_pkg::RST_PHASE,
      stage2Cnt: ccdiv_pkg::RST_STAGE2_CNT,
      bypCtl: ccdiv_pkg::RST_BYP_CTL,
      duty_correction_disable: ccdiv_pkg::RST_DCC_OFF,
      default: '0
   };

   ccdiv_top_st_t s_ff;
   ccdiv_top_st_t nxt_s;
   logic stage1Lvl;
   logic stage2Lvl;
   logic treeRise;
   logic stage1Rise;
   logic ignoreAlign;
   logic forceHigh;
   logic stageHold;

   function automatic logic isMapped(input logic [ccdiv_pkg::IDX_W-1:0] idx);
      isMapped = (idx == ccdiv_pkg::IDX_STAGE1_CNT) || (idx == ccdiv_pkg::IDX_PHASE) ||
         (idx == ccdiv_pkg::IDX_STAGE2_CNT) || (idx == ccdiv_pkg::IDX_BYP_CTL) ||
         (idx == ccdiv_pkg::IDX_DUTY);
   endfunction

   function automatic logic [31:0] readReg(input ccdiv_top_st_t st,
                                           input logic [ccdiv_pkg::IDX_W-1:0] idx);
      readReg = 32'h0000_0000;
      case (idx)
         ccdiv_pkg::IDX_STAGE1_CNT: readReg = {24'h00_0000, st.stage1Cnt};
         ccdiv_pkg::IDX_PHASE: readReg = {24'h00_0000, st.phase};
         ccdiv_pkg::IDX_STAGE2_CNT: readReg = {24'h00_0000, st.stage2Cnt};
         ccdiv_pkg::IDX_BYP_CTL: readReg = {26'h000_0000, st.bypCtl};
         ccdiv_pkg::IDX_DUTY: readReg = {31'h0000_0000, st.duty_correction_disable};
         default: readReg = 32'h0000_0000;
      endcase
   endfunction

   assign ignoreAlign = s_ff.bypCtl[ccdiv_pkg::BIT_IGNORE];
   assign forceHigh = s_ff.bypCtl[ccdiv_pkg::BIT_FORCE];
   // Stages are held only while an alignment request is obeyed.
   assign stageHold = s_ff.alignLvl && !ignoreAlign;
   assign treeRise = s_ff.treeLvl && !s_ff.treePrev;
   // The second stage counts rising edges of the first stage output.
   assign stage1Rise = stage1Lvl && !s_ff.stage1Prev;

   ccdiv_stage u_stage1
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .levelIn(s_ff.treeLvl),
      .tickIn(treeRise),
      .hold(stageHold),
      .bypass(s_ff.bypCtl[ccdiv_pkg::BIT_BYP1]),
      .lowCnt(s_ff.stage1Cnt[ccdiv_pkg::POS_LOW +: 4]),
      .highCnt(s_ff.stage1Cnt[ccdiv_pkg::POS_HIGH +: 4]),
      .phase(s_ff.phase[ccdiv_pkg::POS_PHASE1 +: 4]),
      .startHigh(s_ff.bypCtl[ccdiv_pkg::BIT_START1]),
      .levelOut(stage1Lvl)
   );

   ccdiv_stage u_stage2
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .levelIn(stage1Lvl),
      .tickIn(stage1Rise),
      .hold(stageHold),
      .bypass(s_ff.bypCtl[ccdiv_pkg::BIT_BYP2]),
      .lowCnt(s_ff.stage2Cnt[ccdiv_pkg::POS_LOW +: 4]),
      .highCnt(s_ff.stage2Cnt[ccdiv_pkg::POS_HIGH +: 4]),
      .phase(s_ff.phase[ccdiv_pkg::POS_PHASE2 +: 4]),
      .startHigh(s_ff.bypCtl[ccdiv_pkg::BIT_START2]),
      .levelOut(stage2Lvl)
   );

   always_comb
   begin
      nxt_s = s_ff;

      // Pins pass three flip-flops; a change counts once the last two agree.
      nxt_s.treeSync = {s_ff.treeSync[1:0], clkTreeIn};
      nxt_s.alignSync = {s_ff.alignSync[1:0], alignReq};
      if (s_ff.treeSync[1] == s_ff.treeSync[2])
      begin
         nxt_s.treeLvl = s_ff.treeSync[2];
      end
      if (s_ff.alignSync[1] == s_ff.alignSync[2])
      begin
         nxt_s.alignLvl = s_ff.alignSync[2];
      end
      nxt_s.treePrev = s_ff.treeLvl;
      nxt_s.stage1Prev = stage1Lvl;

      // Write address and data are taken independently, in either order.
      if (s_ff.awRdy && s_axi_awvalid)
      begin
         nxt_s.awHave = 1'b1;
         nxt_s.awIdx = s_axi_awaddr[ccdiv_pkg::ADDR_W-1:2];
      end
      if (s_ff.wRdy && s_axi_wvalid)
      begin
         nxt_s.wHave = 1'b1;
         nxt_s.wData = s_axi_wdata[7:0];
         nxt_s.wLane0 = s_axi_wstrb[0];
      end
      if (s_ff.bValid && s_axi_bready)
      begin
         nxt_s.bValid = 1'b0;
      end
      if (s_ff.awHave && s_ff.wHave && !s_ff.bValid)
      begin
         nxt_s.awHave = 1'b0;
         nxt_s.wHave = 1'b0;
         nxt_s.bValid = 1'b1;
         nxt_s.bResp = isMapped(s_ff.awIdx) ? ccdiv_pkg::RESP_OKAY : ccdiv_pkg::RESP_SLVERR;
         if (s_ff.wLane0)
         begin
            case (s_ff.awIdx)
               ccdiv_pkg::IDX_STAGE1_CNT: nxt_s.stage1Cnt = s_ff.wData;
               ccdiv_pkg::IDX_PHASE: nxt_s.phase = s_ff.wData;
               ccdiv_pkg::IDX_STAGE2_CNT: nxt_s.stage2Cnt = s_ff.wData;
               ccdiv_pkg::IDX_BYP_CTL: nxt_s.bypCtl = s_ff.wData[ccdiv_pkg::CTL_W-1:0];
               ccdiv_pkg::IDX_DUTY: nxt_s.duty_correction_disable = s_ff.wData[ccdiv_pkg::BIT_DCC_OFF];
               default: nxt_s.duty_correction_disable = s_ff.duty_correction_disable;
            endcase
         end
      end
      nxt_s.awRdy = !nxt_s.awHave && !nxt_s.bValid;
      nxt_s.wRdy = !nxt_s.wHave && !nxt_s.bValid;

      // Reads answer one cycle after the address is taken.
      if (s_ff.rValid && s_axi_rready)
      begin
         nxt_s.rValid = 1'b0;
      end
      if (s_ff.arRdy && s_axi_arvalid)
      begin
         nxt_s.rValid = 1'b1;
         nxt_s.rData = readReg(s_ff, s_axi_araddr[ccdiv_pkg::ADDR_W-1:2]);
         nxt_s.rResp = isMapped(s_axi_araddr[ccdiv_pkg::ADDR_W-1:2]) ?
            ccdiv_pkg::RESP_OKAY : ccdiv_pkg::RESP_SLVERR;
      end
      nxt_s.arRdy = !nxt_s.rValid;

      // Forcing only applies to a request that is being ignored.
      if (ignoreAlign && s_ff.alignLvl)
      begin
         nxt_s.chanClk = forceHigh;
      end
      else
      begin
         nxt_s.chanClk = stage2Lvl;
      end
      nxt_s.dutyCorr = !s_ff.duty_correction_disable;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         s_ff <= ST_RST;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign chanClkOut = s_ff.chanClk;
   assign dutyCorrEn = s_ff.dutyCorr;
   assign s_axi_awready = s_ff.awRdy;
   assign s_axi_wready = s_ff.wRdy;
   assign s_axi_bvalid = s_ff.bValid;
   assign s_axi_bresp = s_ff.bResp;
   assign s_axi_arready = s_ff.arRdy;
   assign s_axi_rvalid = s_ff.rValid;
   assign s_axi_rdata = s_ff.rData;
   assign s_axi_rresp = s_ff.rResp;

   ctlReadZero_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (s_ff.arRdy && s_axi_arvalid &&
       s_axi_araddr[ccdiv_pkg::ADDR_W-1:2] == ccdiv_pkg::IDX_BYP_CTL)
      |=> s_axi_rvalid && s_axi_rdata[31:6] == 26'h000_0000)
      else $error("unused control bits read nonzero");

   dutyReadZero_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (s_ff.arRdy && s_axi_arvalid &&
       s_axi_araddr[ccdiv_pkg::ADDR_W-1:2] == ccdiv_pkg::IDX_DUTY)
      |=> s_axi_rvalid && s_axi_rdata[31:1] == 31'h0000_0000)
      else $error("unused duty bits read nonzero");

   forceLevel_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (ignoreAlign && s_ff.alignLvl) |=> chanClkOut == $past(forceHigh))
      else $error("forced output level wrong");

   dutyWrite_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (s_ff.awHave && s_ff.wHave && !s_ff.bValid && s_ff.wLane0 &&
       s_ff.awIdx == ccdiv_pkg::IDX_DUTY) |=> ##1 dutyCorrEn == !$past(s_ff.wData[0], 2))
      else $error("duty correction enable does not follow write");

   ignoreRuns_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (ignoreAlign && !s_ff.bypCtl[ccdiv_pkg::BIT_BYP1] && treeRise && !u_stage1.s_ff.waiting &&
       u_stage1.s_ff.cnt != u_stage1.limit) |=> u_stage1.s_ff.cnt == $past(u_stage1.s_ff.cnt) + 4'h1)
      else $error("ignored alignment request stopped the divider");

   alignStart_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (stageHold && !s_ff.bypCtl[ccdiv_pkg::BIT_BYP2]) ##1 stageHold
      |=> chanClkOut == $past(s_ff.bypCtl[ccdiv_pkg::BIT_START2], 2))
      else $error("output not at start level during alignment");

   cascadeTick_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (!stageHold && !s_ff.bypCtl[ccdiv_pkg::BIT_BYP2] && !stage1Rise) ##1
      (!stageHold && !s_ff.bypCtl[ccdiv_pkg::BIT_BYP2]) |-> $stable(stage2Lvl))
      else $error("second stage moved without a first stage edge");

   respAfterBoth_a: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(s_axi_bvalid) |-> $past(s_ff.awHave && s_ff.wHave))
      else $error("write response before address and data");
endmodule // ccdiv_top

//--- verif/ccdiv_drv_model.sv
// Output driver model: makes the distribution clock and times the channel output.
`timescale 1ns/100ps
module ccdiv_drv_model
(
   // Clock
   input wire logic clk_sys,
   // Distribution clock to the divider, eight system cycles a period
   output logic clkTreeIn,
   // Channel output from the divider
   input wire logic chanClkOut,
   // Last complete high and low widths in system cycles
   output logic [15:0] hiLen,
   output logic [15:0] loLen
);
   logic [2:0] phaseCnt;
   logic [15:0] runLen;
   logic lastLvl;

   initial
   begin
      phaseCnt = 3'h0;
      clkTreeIn = 1'b0;
      runLen = 16'h0000;
      lastLvl = 1'b0;
      hiLen = 16'h0000;
      loLen = 16'h0000;
   end

   // The tree clock runs free, as a distribution clock does.
   always @(posedge clk_sys)
   begin
      phaseCnt <= phaseCnt + 3'h1;
      clkTreeIn <= phaseCnt[2];
      lastLvl <= chanClkOut;
      if (chanClkOut !== lastLvl)
      begin
         runLen <= 16'h0001;
         if (lastLvl === 1'b1)
            hiLen <= runLen;
         else
            loLen <= runLen;
      end
      else
         runLen <= runLen + 16'h0001;
   end
endmodule // ccdiv_drv_model

//--- verif/cascaded_channel_clock_divider_test.sv
// Self-checking testbench for the cascaded channel clock divider.
`timescale 1ns/100ps
module cascaded_channel_clock_divider_test;
   logic clk_sys, rst_n, clkTreeIn, alignReq, chanClkOut, dutyCorrEn;
   logic [15:0] hiLen, loLen;
   logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
   logic [11:0] awAddr, arAddr;
   logic [31:0] wData, rData, data;
   logic [1:0] bResp, rResp, resp;
   logic [15:0] dly [0:2];
   logic [7:0] s1Tab [0:6] = '{8'h00, 8'h01, 8'h10, 8'h55, 8'h13, 8'h00, 8'h00};
   logic [7:0] s2Tab [0:6] = '{8'h00, 8'h02, 8'h30, 8'h31, 8'h00, 8'h00, 8'h00};
   logic [7:0] ctTab [0:6] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h20, 8'h30, 8'h0c};
   logic [15:0] hiTab [0:6] = '{16'h10, 16'h48, 16'h18, 16'h10, 16'h20, 16'h04, 16'h10};
   logic [15:0] loTab [0:6] = '{16'h10, 16'h18, 16'h60, 16'h20, 16'h10, 16'h04, 16'h10};
   logic [7:0] phTab [0:2] = '{8'h00, 8'h30, 8'h02};
   int fails, nCompared, cycles;

   ccdiv_top ccdiv_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .clkTreeIn(clkTreeIn),
      .alignReq(alignReq), .chanClkOut(chanClkOut), .dutyCorrEn(dutyCorrEn),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
      .s_axi_awprot(3'h0), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_bvalid(bValid),
      .s_axi_bready(bReady), .s_axi_bresp(bResp), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_araddr(arAddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp));

   ccdiv_drv_model ccdiv_drv_model_i (.clk_sys(clk_sys), .clkTreeIn(clkTreeIn),
      .chanClkOut(chanClkOut), .hiLen(hiLen), .loLen(loLen));

   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic complete_run();
      $display("compared %0d mismatched %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // A hung handshake ends the run here.
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fails = fails + 1;
         complete_run();
      end
   end

   task automatic chkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
      nCompared++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic axiWr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] r);
      logic done;
      @(posedge clk_sys);
      awAddr <= {idx, 2'b00};
      wData <= {24'h000000, d};
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      done = 1'b0;
      while (!done)
      begin
         @(posedge clk_sys);
         if (awValid && awReady) awValid <= 1'b0;
         if (wValid && wReady) wValid <= 1'b0;
         if (bValid && bReady)
         begin
            done = 1'b1;
            r = bResp;
            bReady <= 1'b0;
         end
      end
   endtask

   task automatic axiRd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic done;
      @(posedge clk_sys);
      arAddr <= {idx, 2'b00};
      arValid <= 1'b1;
      rReady <= 1'b1;
      done = 1'b0;
      while (!done)
      begin
         @(posedge clk_sys);
         if (arValid && arReady) arValid <= 1'b0;
         if (rValid && rReady)
         begin
            done = 1'b1;
            d = rData;
            r = rResp;
            rReady <= 1'b0;
         end
      end
   endtask

   task automatic wrOk(input logic [9:0] idx, input logic [7:0] d);
      logic [1:0] r;
      axiWr(idx, d, r);
      chkVal(32'(r), 32'(ccdiv_pkg::RESP_OKAY), "write response");
   endtask

   task automatic rdChk(input logic [9:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axiRd(idx, d, r);
      chkVal(32'(r), 32'(ccdiv_pkg::RESP_OKAY), "read response");
      chkVal(d, {24'h000000, exp}, "read data");
   endtask

   // Output must stay at one level for longer than any running half period.
   task automatic levelCase(input logic [7:0] ctl, input logic exp);
      wrOk(ccdiv_pkg::IDX_BYP_CTL, ctl);
      repeat (30) @(posedge clk_sys);
      for (int i = 0; i < 4; i++)
      begin
         repeat (9) @(posedge clk_sys);
         chkVal(32'(chanClkOut), 32'(exp), "static level");
      end
   endtask

   // Releases alignment at a fixed tree phase and times the first output rise.
   task automatic alignDelay(output logic [15:0] d);
      alignReq <= 1'b1;
      repeat (40) @(posedge clk_sys);
      @(posedge clkTreeIn);
      @(posedge clk_sys);
      alignReq <= 1'b0;
      d = 16'h0000;
      while (chanClkOut !== 1'b1 && d < 16'd600)
      begin
         @(posedge clk_sys);
         d++;
      end
   endtask

   initial
   begin
      rst_n = 1'b0;
      alignReq = 1'b0;
      {awValid, wValid, bReady, arValid, rReady} = 5'h00;
      awAddr = 12'h000;
      arAddr = 12'h000;
      wData = 32'h00000000;
      fails = 0;
      nCompared = 0;
      cycles = 0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rdChk(ccdiv_pkg::IDX_STAGE1_CNT, 8'h00);
      rdChk(ccdiv_pkg::IDX_PHASE, 8'h00);
      rdChk(ccdiv_pkg::IDX_STAGE2_CNT, 8'h00);
      rdChk(ccdiv_pkg::IDX_BYP_CTL, 8'h00);
      rdChk(ccdiv_pkg::IDX_DUTY, 8'h00);
      chkVal(32'(dutyCorrEn), 32'h1, "duty enable");
      wrOk(ccdiv_pkg::IDX_PHASE, 8'ha5);
      rdChk(ccdiv_pkg::IDX_PHASE, 8'ha5);
      wrOk(ccdiv_pkg::IDX_BYP_CTL, 8'hff);
      rdChk(ccdiv_pkg::IDX_BYP_CTL, 8'h3f);
      wrOk(ccdiv_pkg::IDX_DUTY, 8'hff);
      rdChk(ccdiv_pkg::IDX_DUTY, 8'h01);
      repeat (2) @(posedge clk_sys);
      chkVal(32'(dutyCorrEn), 32'h0, "duty enable");
      axiWr(10'h000, 8'hff, resp);
      chkVal(32'(resp), 32'(ccdiv_pkg::RESP_SLVERR), "unmapped write");
      axiRd(10'h000, data, resp);
      chkVal(32'(resp), 32'(ccdiv_pkg::RESP_SLVERR), "unmapped read");
      chkVal(data, 32'h00000000, "unmapped data");
      wrOk(ccdiv_pkg::IDX_DUTY, 8'h00);
      wrOk(ccdiv_pkg::IDX_PHASE, 8'h00);
      repeat (2) @(posedge clk_sys);
      chkVal(32'(dutyCorrEn), 32'h1, "duty enable");
      $display("test registers done");
      for (int i = 0; i < 7; i++)
      begin
         wrOk(ccdiv_pkg::IDX_STAGE1_CNT, s1Tab[i]);
         wrOk(ccdiv_pkg::IDX_STAGE2_CNT, s2Tab[i]);
         wrOk(ccdiv_pkg::IDX_BYP_CTL, ctTab[i]);
         repeat (300) @(posedge clk_sys);
         chkVal(32'(hiLen), 32'(hiTab[i]), "high width");
         chkVal(32'(loLen), 32'(loTab[i]), "low width");
      end
      $display("test ratios done");
      wrOk(ccdiv_pkg::IDX_STAGE1_CNT, 8'h00);
      wrOk(ccdiv_pkg::IDX_STAGE2_CNT, 8'h00);
      alignReq <= 1'b1;
      levelCase(8'h02, 1'b1);
      levelCase(8'h00, 1'b0);
      levelCase(8'h21, 1'b1);
      levelCase(8'h20, 1'b0);
      levelCase(8'h0c, 1'b1);
      levelCase(8'h08, 1'b0);
      levelCase(8'h04, 1'b0);
      $display("test static levels done");
      wrOk(ccdiv_pkg::IDX_BYP_CTL, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         wrOk(ccdiv_pkg::IDX_PHASE, phTab[i]);
         alignDelay(dly[i]);
      end
      chkVal(32'(dly[1] - dly[0]), 32'd48, "second stage phase");
      chkVal(32'(dly[2] - dly[0]), 32'd16, "first stage phase");
      $display("test phase done");
      complete_run();
   end
endmodule // cascaded_channel_clock_divider_test
